// file: common/dac_ctrl_pkg.sv
package dac_ctrl_pkg;
  // ----------------------------------------------------------------
  // Control register map and layout
  // ----------------------------------------------------------------
  localparam logic [4:0]  CTRL_ADDR      = 5'h01;
  localparam logic [15:0] CTRL_RESET     = 16'h0100;
  localparam logic [15:0] CTRL_WR_MASK   = 16'h03FF;
  localparam int          SINC_EN_BIT    = 9;
  localparam int          DCLK_EN_BIT    = 8;
  localparam int          INTERP_LSB     = 6;
  localparam int          FORMAT_BIT     = 5;
  localparam int          SINGLE_BIT     = 4;
  localparam int          REAL_BIT       = 3;
  localparam int          POLARITY_BIT   = 2;
  localparam int          QFIRST_BIT     = 1;
  localparam int          GAIN_BIT       = 0;
  // Interpolation ratios, one code per rate
  localparam logic [3:0]  INTERP_1X      = 4'h1;
  localparam logic [3:0]  INTERP_2X      = 4'h2;
  localparam logic [3:0]  INTERP_4X      = 4'h4;
  localparam logic [3:0]  INTERP_8X      = 4'h8;
  // ----------------------------------------------------------------
  // Serial port framing and datapath sizes
  // ----------------------------------------------------------------
  localparam logic [4:0]  SPI_INSTR_BITS = 5'h08;
  localparam logic [4:0]  SPI_FRAME_BITS = 5'h18;
  localparam int          READ_BIT       = 7;
  localparam int          WORD_WIDTH     = 16;
  localparam int          FIFO_DEPTH     = 16;
  typedef enum logic [2:0] {
    SPI_IDLE  = 3'h1,
    SPI_INSTR = 3'h2,
    SPI_DATA  = 3'h4
  } spi_state_type;
endpackage

// file: common/pair_fifo_if.sv
interface pair_fifo_if #(parameter int WIDTH = 32);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;
  modport writer (output wr_valid, output wr_data, input wr_ready,
                  input rd_valid, input rd_data, output rd_ready);
  modport store  (input wr_valid, input wr_data, output wr_ready,
                  output rd_valid, output rd_data, input rd_ready);
endinterface

// file: src/pair_fifo.sv
module pair_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic    core_clk,
  input  wire logic    nrst,
  pair_fifo_if.store   bus
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // Honest flags straight from the occupancy count
  assign bus.wr_ready = (count_reg != (AW+1)'(DEPTH));
  assign bus.rd_valid = (count_reg != '0);
  assign bus.rd_data  = mem[rd_ptr_reg];
  assign push         = bus.wr_valid && bus.wr_ready;
  assign pop          = bus.rd_valid && bus.rd_ready;

  // Storage has no reset; only the pointers and the count matter
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= bus.wr_data;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// file: src/dac_datapath_digital_control.sv
module dac_datapath_digital_control #(
  parameter int WIDTH = dac_ctrl_pkg::WORD_WIDTH,
  parameter int DEPTH = dac_ctrl_pkg::FIFO_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             spi_sclk,
  input  wire logic             spi_csb_n,
  input  wire logic             spi_sdi,
  output logic                  spi_sdo,
  output logic                  spi_sdo_oe_n,
  input  wire logic [WIDTH-1:0] first_input_port,
  input  wire logic [WIDTH-1:0] second_input_port,
  input  wire logic             transmit_qualifier_pin,
  input  wire logic [WIDTH-1:0] nco_in,
  output logic [WIDTH-1:0]      nco_scaled,
  output logic                  data_clock_out_pin,
  output logic                  data_clock_out_oe_n,
  output logic [WIDTH-1:0]      i_sample,
  output logic [WIDTH-1:0]      q_sample,
  output logic                  sample_valid,
  input  wire logic             sample_ready,
  output logic                  q_path_enable,
  output logic                  sinc_bypass,
  output logic [3:0]            interp_ratio,
  output logic                  pair_overrun
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 2 * WIDTH + 4;
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic          sclk_d_reg;
  logic [WIDTH-1:0] p1_s, p2_s;
  logic          qual_s, sclk_s, csb_s, sdi_s;
  assign {p1_s, p2_s, qual_s, sclk_s, csb_s, sdi_s} = sync2_reg;

  // Two stages on every pin; only stage two is read
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg  <= SW'(2); // Chip select idles high: no false frame
      sync2_reg  <= SW'(2);
      sclk_d_reg <= 1'b0;
    end else begin
      sync1_reg  <= {first_input_port, second_input_port, transmit_qualifier_pin,
                     spi_sclk, spi_csb_n, spi_sdi};
      sync2_reg  <= sync1_reg;
      sclk_d_reg <= sclk_s;
    end
  end

  // ----------------------------------------------------------------
  // Serial control port
  // ----------------------------------------------------------------
  dac_ctrl_pkg::spi_state_type state_reg;
  logic [4:0]  bit_cnt_reg;
  logic [7:0]  instr_reg;
  logic [15:0] shift_reg;
  logic [15:0] ctrl_reg;
  logic        sclk_rise, sclk_fall, commit;
  assign sclk_rise = sclk_s && !sclk_d_reg;
  assign sclk_fall = !sclk_s && sclk_d_reg;
  assign commit    = (state_reg == dac_ctrl_pkg::SPI_DATA) && sclk_rise && !csb_s
                     && (bit_cnt_reg == dac_ctrl_pkg::SPI_FRAME_BITS - 5'h01)
                     && !instr_reg[dac_ctrl_pkg::READ_BIT]
                     && (instr_reg[4:0] == dac_ctrl_pkg::CTRL_ADDR);

  // Frame: 8 instruction bits then 16 data bits, MSB first
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= dac_ctrl_pkg::SPI_IDLE;
      bit_cnt_reg <= '0;
      instr_reg   <= '0;
    end else if (csb_s) begin
      state_reg   <= dac_ctrl_pkg::SPI_IDLE;
      bit_cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        dac_ctrl_pkg::SPI_IDLE: begin
          state_reg <= dac_ctrl_pkg::SPI_INSTR;
        end
        dac_ctrl_pkg::SPI_INSTR: begin
          if (sclk_rise) begin
            instr_reg   <= {instr_reg[6:0], sdi_s};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == dac_ctrl_pkg::SPI_INSTR_BITS - 5'h01) begin
              state_reg <= dac_ctrl_pkg::SPI_DATA;
            end
          end
        end
        dac_ctrl_pkg::SPI_DATA: begin
          if (sclk_rise) begin
            // After the last bit the port goes to idle, then back to instruction; extra clocks shift into instr_reg
            if (bit_cnt_reg == dac_ctrl_pkg::SPI_FRAME_BITS - 5'h01) begin
              state_reg <= dac_ctrl_pkg::SPI_IDLE;
            end
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
          end
        end
        default: state_reg <= dac_ctrl_pkg::SPI_IDLE;
      endcase
    end
  end

  // Write data in, read data out on the same shifter
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      shift_reg    <= '0;
      spi_sdo      <= 1'b0;
      spi_sdo_oe_n <= 1'b1;
    end else if (csb_s) begin
      spi_sdo_oe_n <= 1'b1;
    end else if (state_reg == dac_ctrl_pkg::SPI_INSTR && sclk_rise
                 && bit_cnt_reg == dac_ctrl_pkg::SPI_INSTR_BITS - 5'h01) begin
      // Unmapped addresses read as zero
      shift_reg <= ({instr_reg[3:0], sdi_s} == dac_ctrl_pkg::CTRL_ADDR) ? ctrl_reg : '0;
    end else if (state_reg == dac_ctrl_pkg::SPI_DATA) begin
      if (sclk_rise && !instr_reg[dac_ctrl_pkg::READ_BIT]) begin
        shift_reg <= {shift_reg[14:0], sdi_s};
      end else if (sclk_fall && instr_reg[dac_ctrl_pkg::READ_BIT]) begin
        spi_sdo      <= shift_reg[15];
        spi_sdo_oe_n <= 1'b0;
        shift_reg    <= {shift_reg[14:0], 1'b0};
      end
    end
  end

  // Control register; unimplemented and reserved bits stay zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= dac_ctrl_pkg::CTRL_RESET;
    end else if (commit) begin
      ctrl_reg <= {shift_reg[14:0], sdi_s} & dac_ctrl_pkg::CTRL_WR_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Mode outputs
  // ----------------------------------------------------------------
  logic dclk_reg;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sinc_bypass         <= 1'b1;
      interp_ratio        <= dac_ctrl_pkg::INTERP_1X;
      q_path_enable       <= 1'b1;
      nco_scaled          <= '0;
      dclk_reg            <= 1'b0;
      data_clock_out_pin  <= 1'b0;
      data_clock_out_oe_n <= 1'b1;
    end else begin
      sinc_bypass   <= !ctrl_reg[dac_ctrl_pkg::SINC_EN_BIT];
      q_path_enable <= !ctrl_reg[dac_ctrl_pkg::REAL_BIT];
      unique case (ctrl_reg[dac_ctrl_pkg::INTERP_LSB +: 2])
        2'h0: interp_ratio <= dac_ctrl_pkg::INTERP_1X;
        2'h1: interp_ratio <= dac_ctrl_pkg::INTERP_2X;
        2'h2: interp_ratio <= dac_ctrl_pkg::INTERP_4X;
        2'h3: interp_ratio <= dac_ctrl_pkg::INTERP_8X;
      endcase
      // Arithmetic shift keeps the sign of the oscillator word
      nco_scaled <= ctrl_reg[dac_ctrl_pkg::GAIN_BIT] ?
                    WIDTH'($signed(nco_in) >>> 1) : nco_in;
      // Divided clock; held low while the pin is disabled
      dclk_reg            <= ctrl_reg[dac_ctrl_pkg::DCLK_EN_BIT] ? !dclk_reg : 1'b0;
      data_clock_out_pin  <= dclk_reg;
      data_clock_out_oe_n <= !ctrl_reg[dac_ctrl_pkg::DCLK_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Input data assembler
  // ----------------------------------------------------------------
  function automatic logic [WIDTH-1:0] to_twos(input logic [WIDTH-1:0] w, input logic ob);
    to_twos = ob ? {~w[WIDTH-1], w[WIDTH-2:0]} : w;
  endfunction

  pair_fifo_if #(.WIDTH(2 * WIDTH)) fifo_bus ();
  logic [WIDTH-1:0] held_reg, w1, w2;
  logic             held_ok_reg, single, qfirst, is_i, take_pair;
  logic [2*WIDTH-1:0] pair_reg;
  logic             pair_valid_reg;
  assign single = ctrl_reg[dac_ctrl_pkg::SINGLE_BIT];
  assign qfirst = ctrl_reg[dac_ctrl_pkg::QFIRST_BIT];
  assign w1     = to_twos(p1_s, ctrl_reg[dac_ctrl_pkg::FORMAT_BIT]);
  assign w2     = to_twos(p2_s, ctrl_reg[dac_ctrl_pkg::FORMAT_BIT]);
  assign is_i   = qual_s ^ ctrl_reg[dac_ctrl_pkg::POLARITY_BIT];
  // A pair forms every cycle in dual mode, on the closing word otherwise
  assign take_pair = !single || (held_ok_reg && (is_i == qfirst));
  assign fifo_bus.wr_valid = pair_valid_reg;
  assign fifo_bus.wr_data  = pair_reg;

  // Single-port words come one per clock at twice the pair rate
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      held_reg    <= '0;
      held_ok_reg <= 1'b0;
    end else if (!single) begin
      held_ok_reg <= 1'b0;
    end else if (is_i != qfirst) begin
      held_reg    <= w1;
      held_ok_reg <= 1'b1;
    end
  end

  // Pair stage stalls on a full store; a pair lost then flags overrun
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pair_reg       <= '0;
      pair_valid_reg <= 1'b0;
      pair_overrun   <= 1'b0;
    end else begin
      if (!pair_valid_reg || fifo_bus.wr_ready) begin
        pair_valid_reg <= take_pair;
        if (take_pair) begin
          pair_reg <= !single ? {w1, w2} :
                      (qfirst ? {w1, held_reg} : {held_reg, w1});
        end
      end else if (take_pair) begin
        pair_overrun <= 1'b1;
      end
    end
  end

  pair_fifo #(.WIDTH(2 * WIDTH), .DEPTH(DEPTH)) u_store (
    .core_clk (core_clk),
    .nrst     (nrst),
    .bus      (fifo_bus.store)
  );

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  logic rd_fire;
  assign fifo_bus.rd_ready = !sample_valid || sample_ready;
  assign rd_fire           = fifo_bus.rd_ready && fifo_bus.rd_valid;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      i_sample     <= '0;
      q_sample     <= '0;
      sample_valid <= 1'b0;
    end else if (fifo_bus.rd_ready) begin
      sample_valid <= fifo_bus.rd_valid;
      if (fifo_bus.rd_valid) begin
        i_sample <= fifo_bus.rd_data[2*WIDTH-1:WIDTH];
        q_sample <= ctrl_reg[dac_ctrl_pkg::REAL_BIT] ? '0 : fifo_bus.rd_data[WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  reserved_zero_a: assert property (ctrl_reg[15:10] == 6'h00)
    else $error("reserved control bits not zero");
  reg_write_a: assert property (commit |=> ctrl_reg ==
      ($past({shift_reg[14:0], sdi_s}) & dac_ctrl_pkg::CTRL_WR_MASK))
    else $error("control write not stored");
  sinc_bypass_a: assert property ($rose(ctrl_reg[9]) |=> !sinc_bypass)
    else $error("sinc filter not enabled");
  dclk_pin_a: assert property (!ctrl_reg[8] |=> data_clock_out_oe_n ##1 !data_clock_out_pin)
    else $error("data clock pin not disabled");
  interp_rate_a: assert property (##1 interp_ratio ==
      (4'h1 << $past(ctrl_reg[7:6])))
    else $error("interpolation ratio mismatch");
  dual_pair_a: assert property (!single && (!pair_valid_reg || fifo_bus.wr_ready)
      |=> pair_valid_reg && pair_reg == {$past(w1), $past(w2)})
    else $error("dual port pair wrong");
  inorder_pair_a: assert property ((single && !qfirst && held_ok_reg && !is_i
      && !pair_valid_reg) |=> pair_reg == {$past(held_reg), $past(w1)})
    else $error("I then Q pairing wrong");
  qfirst_pair_a: assert property ((single && qfirst && held_ok_reg && is_i
      && !pair_valid_reg) |=> pair_reg == {$past(w1), $past(held_reg)})
    else $error("Q first pairing wrong");
  real_mode_a: assert property ((rd_fire && ctrl_reg[3]) |=> q_sample == '0)
    else $error("Q path not disabled");
  gain_half_a: assert property (ctrl_reg[0] |=> nco_scaled ==
      WIDTH'($signed($past(nco_in)) >>> 1))
    else $error("oscillator gain not halved");
  dual_flow_c: cover property (!single && sample_valid && sample_ready);
  single_flow_c: cover property (single && qfirst && pair_valid_reg);
  spi_write_c: cover property (commit);
  store_full_c: cover property (!fifo_bus.wr_ready ##1 pair_overrun);
endmodule

// file: bench/baseband_source.sv
module baseband_source (
  input  wire logic   core_clk,
  input  wire logic   nrst,
  input  wire logic   single_mode,
  input  wire logic   invert_qual,
  output logic [15:0] first_input_port,
  output logic [15:0] second_input_port,
  output logic        transmit_qualifier_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] count_reg;
  // ----------------------------------------
  // Word stream
  // ----------------------------------------
  // One new word per cycle, launched just after the edge
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= 12'h000;
    end else begin
      count_reg <= #5 count_reg + 12'h001;
    end
  end
  // Dual: both words together single: I on even, Q on odd, twice pair rate
  // Unused second port keeps changing, so stale data never looks like a match
  always_comb begin
    if (single_mode) begin
      first_input_port  = {count_reg[0] ? 4'h5 : 4'h3, count_reg};
      second_input_port = {4'hA, ~count_reg};
    end else begin
      first_input_port  = {4'h3, count_reg};
      second_input_port = {4'h5, count_reg};
    end
    transmit_qualifier_pin = ~count_reg[0] ^ invert_qual; // High marks I unless inverted
  end
endmodule

// file: bench/dac_datapath_digital_control_tb_top.sv
module dac_datapath_digital_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk;
  logic        nrst;
  logic        spi_sclk;
  logic        spi_csb_n;
  logic        spi_sdi;
  logic        spi_sdo;
  logic        spi_sdo_oe_n;
  logic [15:0] first_input_port;
  logic [15:0] second_input_port;
  logic        transmit_qualifier_pin;
  logic [15:0] nco_in;
  logic [15:0] nco_scaled;
  logic        data_clock_out_pin;
  logic        data_clock_out_oe_n;
  logic [15:0] i_sample;
  logic [15:0] q_sample;
  logic        sample_valid;
  logic        sample_ready;
  logic        q_path_enable;
  logic        sinc_bypass;
  logic [3:0]  interp_ratio;
  logic        pair_overrun;
  logic        src_single;
  logic        src_invert;
  logic        seen;
  int          errors;
  int          n_checks;
  dac_datapath_digital_control dac_datapath_digital_control_i (
    .core_clk(core_clk), .nrst(nrst), .spi_sclk(spi_sclk), .spi_csb_n(spi_csb_n),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n),
    .first_input_port(first_input_port), .second_input_port(second_input_port),
    .transmit_qualifier_pin(transmit_qualifier_pin), .nco_in(nco_in),
    .nco_scaled(nco_scaled), .data_clock_out_pin(data_clock_out_pin),
    .data_clock_out_oe_n(data_clock_out_oe_n), .i_sample(i_sample), .q_sample(q_sample),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .q_path_enable(q_path_enable), .sinc_bypass(sinc_bypass),
    .interp_ratio(interp_ratio), .pair_overrun(pair_overrun));
  baseband_source baseband_source_i (
    .core_clk(core_clk), .nrst(nrst), .single_mode(src_single), .invert_qual(src_invert),
    .first_input_port(first_input_port), .second_input_port(second_input_port),
    .transmit_qualifier_pin(transmit_qualifier_pin));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Inputs always move 5 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask
  // Six core cycles per serial half period, well above the three-cycle sync delay
  task automatic spi_frame(input logic [7:0] instr, input logic [15:0] wdata,
                           output logic [15:0] rdata);
    logic [23:0] frame;
    frame = {instr, wdata};
    rdata = 16'h0000;
    tick(1);
    spi_csb_n = 1'b0;
    for (int b = 23; b >= 0; b--) begin
      spi_sdi = frame[b];
      tick(6);
      // Released line floats to its pull-up level
      if (b < 16) rdata[b] = spi_sdo_oe_n ? 1'b1 : spi_sdo;
      if (b == 0) check("oe_n", {15'h0000, !instr[7]}, {15'h0000, spi_sdo_oe_n});
      spi_sclk = 1'b1;
      tick(6);
      spi_sclk = 1'b0;
    end
    tick(6);
    spi_csb_n = 1'b1;
    tick(6);
    check("oe_n idle", 16'h0001, {15'h0000, spi_sdo_oe_n});
  endtask
  task automatic reg_write(input logic [4:0] addr, input logic [15:0] value);
    logic [15:0] unused;
    spi_frame({3'h0, addr}, value, unused);
  endtask
  task automatic reg_read_check(input logic [4:0] addr, input logic [15:0] exp);
    logic [15:0] got;
    spi_frame({3'h4, addr}, 16'h0000, got);
    check("register read", exp, got);
  endtask
  // The source follows the port mode that software selects
  task automatic set_ctrl(input logic [15:0] value);
    reg_write(dac_ctrl_pkg::CTRL_ADDR, value);
    src_single = value[4];
    src_invert = value[2];
  endtask
  // Skips the pairs still in flight from the old mode, then judges eight
  task automatic check_stream(input logic [3:0] i_top, input logic [3:0] q_top,
                              input logic [11:0] delta, input logic real_mode);
    int got;
    int waited;
    got = 0;
    waited = 0;
    tick(30);
    while (got < 8 && waited < 60) begin
      @(negedge core_clk);
      waited++;
      if (sample_valid === 1'b1) begin
        got++;
        check("i word", {12'h000, i_top}, {12'h000, i_sample[15:12]});
        check("q word", real_mode ? 16'h0000 : {q_top, i_sample[11:0] + delta}, q_sample);
      end
    end
    check("sample count", 16'h0008, got[15:0]);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset;
    check("sinc_bypass", 16'h0001, {15'h0000, sinc_bypass});
    check("interp_ratio", 16'h0001, {12'h000, interp_ratio});
    check("q_path_enable", 16'h0001, {15'h0000, q_path_enable});
    check("clock oe_n", 16'h0000, {15'h0000, data_clock_out_oe_n});
    @(negedge core_clk);
    seen = data_clock_out_pin;
    @(negedge core_clk);
    check("clock toggle", {15'h0000, ~seen}, {15'h0000, data_clock_out_pin});
    reg_read_check(dac_ctrl_pkg::CTRL_ADDR, 16'h0100);
    $display("test_reset done");
  endtask
  task automatic test_fields;
    set_ctrl(16'hFFFF);
    reg_read_check(dac_ctrl_pkg::CTRL_ADDR, 16'h03FF);
    check("sinc_bypass", 16'h0000, {15'h0000, sinc_bypass});
    check("q_path_enable", 16'h0000, {15'h0000, q_path_enable});
    reg_write(5'h02, 16'h0000);
    reg_read_check(5'h02, 16'h0000);
    reg_read_check(dac_ctrl_pkg::CTRL_ADDR, 16'h03FF);
    for (int c = 0; c < 4; c++) begin
      set_ctrl({8'h00, c[1:0], 6'h00});
      check("interp_ratio", 16'h0001 << c, {12'h000, interp_ratio});
    end
    check("clock oe_n off", 16'h0001, {15'h0000, data_clock_out_oe_n});
    check("clock pin off", 16'h0000, {15'h0000, data_clock_out_pin});
    $display("test_fields done");
  endtask
  task automatic test_gain;
    nco_in = 16'h8004;
    set_ctrl(16'h0100);
    check("nco plain", 16'h8004, nco_scaled);
    set_ctrl(16'h0101);
    check("nco halved", 16'hC002, nco_scaled);
    $display("test_gain done");
  endtask
  task automatic test_streams;
    set_ctrl(16'h0100);
    check_stream(4'h3, 4'h5, 12'h000, 1'b0);
    set_ctrl(16'h0120);
    check_stream(4'hB, 4'hD, 12'h000, 1'b0);
    set_ctrl(16'h0108);
    check_stream(4'h3, 4'h5, 12'h000, 1'b1);
    // Every polarity and pairing order in single-port mode
    for (int m = 0; m < 4; m++) begin
      set_ctrl({8'h01, 3'h0, 1'b1, 1'b0, m[1], m[0], 1'b0});
      check_stream(4'h3, 4'h5, m[0] ? 12'hFFF : 12'h001, 1'b0);
    end
    $display("test_streams done");
  endtask
  // Overrun is sticky, so this one runs last
  task automatic test_stall;
    logic [15:0] held;
    logic [11:0] prev;
    set_ctrl(16'h0100);
    tick(30);
    check("overrun before stall", 16'h0000, {15'h0000, pair_overrun});
    sample_ready = 1'b0;
    tick(1);
    held = i_sample;
    tick(40);
    check("stalled valid", 16'h0001, {15'h0000, sample_valid});
    check("stalled word", held, i_sample);
    check("overrun flag", 16'h0001, {15'h0000, pair_overrun});
    sample_ready = 1'b1;
    @(negedge core_clk);
    prev = i_sample[11:0];
    for (int n = 0; n < 16; n++) begin
      @(negedge core_clk);
      if (sample_valid === 1'b1) begin
        check("drained order", {4'h3, prev + 12'h001}, i_sample);
        prev = i_sample[11:0];
      end
    end
    $display("test_stall done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    nrst = 1'b0;
    spi_sclk = 1'b0;
    spi_csb_n = 1'b1;
    spi_sdi = 1'b0;
    nco_in = 16'h0000;
    sample_ready = 1'b1;
    src_single = 1'b0;
    src_invert = 1'b0;
    errors = 0;
    n_checks = 0;
    repeat (6) @(posedge core_clk);
    #5;
    nrst = 1'b1;
    tick(4);
    test_reset;
    test_fields;
    test_gain;
    test_streams;
    test_stall;
    end_of_test;
  end
  // About 6400 cycles expected; give it five times that
  initial begin
    #3200000;
    errors++;
    end_of_test;
  end
endmodule
